/* clock_strap_and_output_gating.v */
`timescale 1ns/10ps
`include "clock_strap_defines.vh"
module clock_strap_and_output_gating #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input wire clk_sys,
  input wire reset_n,
  input wire power_good,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // dual-purpose pins: [0] freq0 / 24, [1] freq1 / 48, [2] freq2 / free bus,
  // [3] mode / free graphics, [4] memory source / reference
  input wire [4:0] strap_pin_in,
  output reg [4:0] strap_pin_out,
  output reg [4:0] strap_pin_oe_n,
  // shared pins: [0] memory 4 / graphics halt, [1] memory 5 / power-down,
  // [2] memory 6 / processor halt, [3] memory 7 / bus halt
  input wire [3:0] shared_memory_clock_pins_in,
  output wire [3:0] shared_memory_clock_pins_out,
  output reg [3:0] shared_memory_clock_pins_oe_n,
  output wire [3:0] processor_clock_outputs,
  output wire [7:0] memory_clock_outputs,
  output wire [4:0] local_bus_clock_outputs,
  output wire graphics_port_clock_output,
  output reg straps_latched
);
  // ************************************************************
  // declarations
  // ************************************************************
  localparam ST_WAIT_PG = 2'd0;
  localparam ST_SAMPLE = 2'd1;
  localparam ST_LATCH = 2'd2;
  localparam ST_RUN = 2'd3;
  localparam [31:0] SAMPLE_LAST_W = SAMPLE_CYCLES - 1;
  localparam [17:0] SAMPLE_LAST = SAMPLE_LAST_W[17:0];
  localparam [31:0] STEP_LAST_W = `SPREAD_STEP_CYCLES - 1;
  localparam [7:0] STEP_LAST = STEP_LAST_W[7:0];
  localparam [31:0] PROC_TABLE = `PROC_HALF_TABLE;
  localparam [31:0] GFX_TABLE = `GFX_HALF_TABLE;

  reg [1:0] state_q;
  reg [17:0] timer_q;
  reg [4:0] strap_q;
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  reg [9:0] sync3_q;
  reg [9:0] stable_q;
  reg [31:0] ctrl_q;
  reg [31:0] disable_q;
  reg [7:0] address_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [31:0] rd_mux;
  reg [3:0] proc_cnt_q;
  reg proc_ph_q;
  reg [3:0] gfx_cnt_q;
  reg gfx_ph_q;
  reg bus_ph_q;
  reg [7:0] ref_cnt_q;
  reg ref_ph_q;
  reg [7:0] f48_cnt_q;
  reg f48_ph_q;
  reg f24_ph_q;
  reg [7:0] step_cnt_q;
  reg [7:0] ramp_cnt_q;
  reg ramp_up_q;
  reg stretch_q;
  reg shrink_q;
  wire running;
  wire mode_clk;
  wire pg_stable;
  wire gfx_halt_n;
  wire all_clocks_off_n;
  wire proc_halt_n;
  wire bus_halt_n;
  wire [2:0] freq_sel;
  wire spread_on;
  wire [3:0] proc_half;
  wire [3:0] proc_half_mod;
  wire [3:0] gfx_half;
  wire mem_phase;
  wire [31:0] on;
  wire [3:0] proc_lane;
  wire [11:0] mem_lane;
  wire [4:0] bus_lane;
  wire [4:0] strap_lane;
  wire gfx_lane;
  wire ahb_take;

  // ************************************************************
  // pin synchronisers: straps, shared pins, power good
  // ************************************************************
  // third flop only joins the vote; first flop feeds nothing else
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      sync3_q <= 10'h000;
      stable_q <= 10'h000;
    end else begin
      sync1_q <= {power_good, shared_memory_clock_pins_in, strap_pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stable_q <= (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
    end
  end

  assign pg_stable = stable_q[9];
  assign running = (state_q == ST_RUN);
  assign mode_clk = strap_q[3];
  // halts only exist in input mode; otherwise treated as inactive
  assign gfx_halt_n = mode_clk | stable_q[5];
  assign all_clocks_off_n = mode_clk | stable_q[6];
  assign proc_halt_n = mode_clk | stable_q[7];
  assign bus_halt_n = mode_clk | stable_q[8];

  // ************************************************************
  // strap sampling sequence
  // ************************************************************
  // only reset_n (power cycle) restarts this; power_good loss does not
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_WAIT_PG;
      timer_q <= 18'h00000;
      strap_q <= 5'h00;
      straps_latched <= 1'b0;
    end else begin
      case (state_q)
        ST_WAIT_PG: begin
          if (pg_stable) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (timer_q == SAMPLE_LAST) begin
            state_q <= ST_LATCH;
          end else begin
            timer_q <= timer_q + 18'h00001;
          end
        end
        ST_LATCH: begin
          strap_q <= stable_q[4:0];
          straps_latched <= 1'b1;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_WAIT_PG;
        end
      endcase
    end
  end

  // ************************************************************
  // ahb-lite register slave, zero wait states
  // ************************************************************
  assign ahb_take = hsel & htrans[1] & hready;

  always @* begin
    case (haddr[7:0])
      `REG_CTRL: rd_mux = ctrl_q;
      `REG_DISABLE: rd_mux = disable_q;
      `REG_STATUS: rd_mux = {22'h000000, stable_q[8:5], running, strap_q};
      `REG_ADDRESS: rd_mux = {24'h000000, address_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // config writes land only while the address register holds the key
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      disable_q <= `DISABLE_RESET;
      address_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= ahb_take & hwrite;
      if (ahb_take) begin
        wr_addr_q <= haddr[7:0];
      end
      if (ahb_take && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_q) begin
        if (wr_addr_q == `REG_ADDRESS) begin
          address_q <= hwdata[7:0];
        end else if (address_q == `SLAVE_ADDRESS) begin
          if (wr_addr_q == `REG_CTRL) begin
            ctrl_q <= {26'h0000000, hwdata[5:0]};
          end else if (wr_addr_q == `REG_DISABLE) begin
            disable_q <= {5'h00, hwdata[26:0]};
          end
        end
      end
    end
  end

  // ************************************************************
  // frequency selection and spread
  // ************************************************************
  assign freq_sel = ctrl_q[`CTRL_OVERRIDE_BIT] ?
    ctrl_q[`CTRL_FREQ_LSB+2:`CTRL_FREQ_LSB] : strap_q[2:0];
  assign spread_on = |ctrl_q[`CTRL_SPREAD_LSB+1:`CTRL_SPREAD_LSB];
  assign proc_half = PROC_TABLE[{freq_sel, 2'b00} +: 4];
  assign gfx_half = GFX_TABLE[{freq_sel, 2'b00} +: 4];
  // one cycle of every 200 added or removed gives the 0.5 percent swing
  assign proc_half_mod = stretch_q ? proc_half + 4'h1 :
    (shrink_q ? proc_half - 4'h1 : proc_half);

  // triangle ramp: deviation sign flips every ramp
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_q <= 8'h00;
      ramp_cnt_q <= 8'h00;
      ramp_up_q <= 1'b1;
      stretch_q <= 1'b0;
      shrink_q <= 1'b0;
    end else begin
      if (proc_cnt_q == 4'h1) begin
        stretch_q <= 1'b0;
        shrink_q <= 1'b0;
      end
      if (!spread_on) begin
        step_cnt_q <= 8'h00;
      end else if (step_cnt_q == STEP_LAST) begin
        step_cnt_q <= 8'h00;
        stretch_q <= ramp_up_q;
        shrink_q <= ~ramp_up_q;
        if (ramp_cnt_q == `SPREAD_STEPS_PER_RAMP - 8'h01) begin
          ramp_cnt_q <= 8'h00;
          ramp_up_q <= ~ramp_up_q;
        end else begin
          ramp_cnt_q <= ramp_cnt_q + 8'h01;
        end
      end else begin
        step_cnt_q <= step_cnt_q + 8'h01;
      end
    end
  end

  // ************************************************************
  // phase generators
  // ************************************************************
  // dividers start at first enable; first processor half may be short
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      proc_cnt_q <= 4'h0;
      proc_ph_q <= 1'b0;
      gfx_cnt_q <= 4'h0;
      gfx_ph_q <= 1'b0;
      bus_ph_q <= 1'b0;
      ref_cnt_q <= 8'h00;
      ref_ph_q <= 1'b0;
      f48_cnt_q <= 8'h00;
      f48_ph_q <= 1'b0;
      f24_ph_q <= 1'b0;
    end else if (running) begin
      if (proc_cnt_q <= 4'h1) begin
        proc_cnt_q <= proc_half_mod;
        proc_ph_q <= ~proc_ph_q;
      end else begin
        proc_cnt_q <= proc_cnt_q - 4'h1;
      end
      if (gfx_cnt_q <= 4'h1) begin
        gfx_cnt_q <= gfx_half;
        gfx_ph_q <= ~gfx_ph_q;
        if (!gfx_ph_q) begin
          bus_ph_q <= ~bus_ph_q; // bus runs at half graphics rate
        end
      end else begin
        gfx_cnt_q <= gfx_cnt_q - 4'h1;
      end
      if (ref_cnt_q <= 8'h01) begin
        ref_cnt_q <= `REF_HALF;
        ref_ph_q <= ~ref_ph_q;
      end else begin
        ref_cnt_q <= ref_cnt_q - 8'h01;
      end
      if (f48_cnt_q <= 8'h01) begin
        f48_cnt_q <= `F48_HALF;
        f48_ph_q <= ~f48_ph_q;
        if (!f48_ph_q) begin
          f24_ph_q <= ~f24_ph_q;
        end
      end else begin
        f48_cnt_q <= f48_cnt_q - 8'h01;
      end
    end
  end

  assign mem_phase = strap_q[4] ? proc_ph_q : gfx_ph_q;

  // ************************************************************
  // output enables per lane
  // ************************************************************
  // power-down and individual disables cover every output
  assign on = ~disable_q & {32{running & all_clocks_off_n}};
  assign proc_lane = on[`DIS_PROC_LSB+3:`DIS_PROC_LSB] & {4{proc_halt_n}};
  assign mem_lane = on[`DIS_MEM_LSB+11:`DIS_MEM_LSB] & {12{proc_halt_n}};
  assign bus_lane = on[`DIS_BUS_LSB+4:`DIS_BUS_LSB] & {5{bus_halt_n}};
  assign gfx_lane = on[`DIS_GFX_BIT] & gfx_halt_n;

  clock_gate_lane #(.WIDTH(4)) u_proc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(proc_ph_q),
    .allow(proc_lane),
    .clk_q(processor_clock_outputs)
  );

  clock_gate_lane #(.WIDTH(12)) u_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(mem_phase),
    // shared pins carry memory 4..7; the plain outputs carry 0..3 and 8..11
    .allow({mem_lane[7:4], mem_lane[11:8], mem_lane[3:0]}),
    .clk_q({shared_memory_clock_pins_out, memory_clock_outputs})
  );

  clock_gate_lane #(.WIDTH(5)) u_bus (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(bus_ph_q),
    .allow(bus_lane),
    .clk_q(local_bus_clock_outputs)
  );

  clock_gate_lane #(.WIDTH(1)) u_gfx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(gfx_ph_q),
    .allow(gfx_lane),
    .clk_q(graphics_port_clock_output)
  );

  // free-running clocks obey only power-down and disables
  clock_gate_lane #(.WIDTH(1)) u_f24 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(f24_ph_q),
    .allow(on[`DIS_24_BIT]),
    .clk_q(strap_lane[0])
  );

  clock_gate_lane #(.WIDTH(1)) u_f48 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(f48_ph_q),
    .allow(on[`DIS_48_BIT]),
    .clk_q(strap_lane[1])
  );

  clock_gate_lane #(.WIDTH(1)) u_bus_free (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(bus_ph_q),
    .allow(on[`DIS_BUS_FREE_BIT]),
    .clk_q(strap_lane[2])
  );

  clock_gate_lane #(.WIDTH(1)) u_gfx_free (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(gfx_ph_q),
    .allow(on[`DIS_GFX_FREE_BIT]),
    .clk_q(strap_lane[3])
  );

  clock_gate_lane #(.WIDTH(1)) u_ref (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(ref_ph_q),
    .allow(on[`DIS_REF_BIT]),
    .clk_q(strap_lane[4])
  );

  // ************************************************************
  // pin drivers
  // ************************************************************
  // buffers stay off until the latch state has passed
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_pin_out <= 5'h00;
      strap_pin_oe_n <= 5'h1F;
      shared_memory_clock_pins_oe_n <= 4'hF;
    end else begin
      strap_pin_out <= strap_lane;
      strap_pin_oe_n <= {5{~running}};
      shared_memory_clock_pins_oe_n <= {4{~(running & mode_clk)}};
    end
  end
endmodule // clock_strap_and_output_gating

/* clock_strap_defines.vh */
// Function
// - memory-source strap 1: memory clocks at processor rate; 0: at graphics rate
// - mode strap 1: shared pins are memory clocks 7..4; 0: halt/power-down inputs
// - processor halt low holds processor and all memory clocks low
// - bus halt low holds the five gated local bus clocks low
// - graphics halt low holds the gated graphics clock low
// - power-down low drives every clock output low until it returns high
// - dual-purpose pins start as inputs, become clock outputs after latching
// - dual-purpose output buffers stay high impedance through the 2 ms window
// - strap levels latched at window end, buffers enabled only afterwards
// - window timer starts when the power-good detect asserts
// - latched straps hold until power is removed and reapplied
// - first processor clock cycle after enabling may be shortened
// - frequency from latched straps by default, serial selection as alternative
// - spread on: processor clock modulated by plus or minus 0.5 percent
// - spread switched by bits 1-0 of the first configuration data byte
// - each output individually disableable; disabled outputs held low
// - free-running bus and graphics clocks ignore the halt inputs
// - configuration writes apply only when the slave address is 11010010
`ifndef CLOCK_STRAP_DEFINES_VH
`define CLOCK_STRAP_DEFINES_VH

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define SAMPLE_WINDOW_MS 2
`define SAMPLE_CYCLES (`SAMPLE_WINDOW_MS * 1000000 / `CLK_PERIOD_NS)
// 0.5 percent deviation: one cycle shift in every 200
`define SPREAD_PERMILLE 5
`define SPREAD_STEP_CYCLES (1000 / `SPREAD_PERMILLE)
`define SPREAD_STEPS_PER_RAMP 8'h20

// ************************************************************
// register map
// ************************************************************
`define REG_CTRL 8'h00
`define REG_DISABLE 8'h04
`define REG_STATUS 8'h08
`define REG_ADDRESS 8'h0C
`define SLAVE_ADDRESS 8'hD2
`define CTRL_SPREAD_LSB 0
`define CTRL_OVERRIDE_BIT 2
`define CTRL_FREQ_LSB 3
`define CTRL_RESET 32'h0000_0000
`define DISABLE_RESET 32'h0000_0000

// disable mask fields
`define DIS_PROC_LSB 0
`define DIS_MEM_LSB 4
`define DIS_BUS_LSB 16
`define DIS_BUS_FREE_BIT 21
`define DIS_GFX_BIT 22
`define DIS_GFX_FREE_BIT 23
`define DIS_REF_BIT 24
`define DIS_48_BIT 25
`define DIS_24_BIT 26

// ************************************************************
// divider half periods in clk_sys cycles
// ************************************************************
`define PROC_HALF_TABLE 32'h3242_5354
`define GFX_HALF_TABLE 32'h5464_6575
`define REF_HALF 8'h07
`define F48_HALF 8'h02

`endif

/* clock_gate_lane.v */
`timescale 1ns/10ps
// ************************************************************
// glitch-free gate for a group of outputs sharing one phase
// ************************************************************
module clock_gate_lane #(
  parameter WIDTH = 1
) (
  input wire clk_sys,
  input wire reset_n,
  input wire phase,
  input wire [WIDTH-1:0] allow,
  output reg [WIDTH-1:0] clk_q
);
  reg [WIDTH-1:0] allow_q;

  // enable only moves while the phase is low, so no runt pulse
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      allow_q <= {WIDTH{1'b0}};
    end else if (!phase) begin
      allow_q <= allow;
    end
  end

  // registered output, low whenever gated
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_q <= {WIDTH{1'b0}};
    end else begin
      clk_q <= {WIDTH{phase}} & allow_q;
    end
  end
endmodule // clock_gate_lane

/* clock_gating_props.sv */
`timescale 1ns/10ps
// ****************
// strap window and clock gating checks
// ****************
module clock_gating_props #(
  parameter SAMPLE_CYCLES = 20
) (
  input wire clk_sys,
  input wire reset_n,
  input wire power_good,
  input wire [4:0] strap_pin_out,
  input wire [4:0] strap_pin_oe_n,
  input wire [3:0] shared_memory_clock_pins_in,
  input wire [3:0] shared_memory_clock_pins_oe_n,
  input wire [3:0] processor_clock_outputs,
  input wire [7:0] memory_clock_outputs,
  input wire [4:0] local_bus_clock_outputs,
  input wire graphics_port_clock_output,
  input wire straps_latched
);
  localparam int WIN_HI = SAMPLE_CYCLES + 12;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  reg [4:0] low_q [0:3];
  reg [31:0] pg_q;
  integer i;
  wire halt_mode = straps_latched && (shared_memory_clock_pins_oe_n == 4'hF);
  // low-time counters: the long wait covers sync and waiting for a low phase
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pg_q <= 32'h0;
      for (i = 0; i < 4; i = i + 1) low_q[i] <= 5'h00;
    end else begin
      pg_q <= power_good ? pg_q + 32'h1 : 32'h0;
      for (i = 0; i < 4; i = i + 1)
        low_q[i] <= (!halt_mode || shared_memory_clock_pins_in[i]) ? 5'h00 :
                    (low_q[i] == 5'h1F) ? low_q[i] : low_q[i] + 5'h01;
    end
  end
  sequence s_latch_step;
    !straps_latched ##1 straps_latched;
  endsequence
  property p_hiz; !straps_latched |-> strap_pin_oe_n == 5'h1F; endproperty
  property p_enable; s_latch_step |-> strap_pin_oe_n == 5'h1F ##[1:8] strap_pin_oe_n == 5'h00;
  endproperty
  property p_hold; straps_latched |=> straps_latched; endproperty
  property p_window; $rose(straps_latched) |-> pg_q >= SAMPLE_CYCLES && pg_q <= WIN_HI;
  endproperty
  property p_mode; strap_pin_oe_n == 5'h00 |->
    shared_memory_clock_pins_oe_n == 4'h0 || shared_memory_clock_pins_oe_n == 4'hF; endproperty
  property p_proc; low_q[2] >= 5'h1E |->
    processor_clock_outputs == 4'h0 && memory_clock_outputs == 8'h00; endproperty
  property p_bus; low_q[3] >= 5'h1E |-> local_bus_clock_outputs == 5'h00; endproperty
  property p_gfx; low_q[0] >= 5'h1E |-> !graphics_port_clock_output; endproperty
  property p_down; low_q[1] >= 5'h1E |-> {processor_clock_outputs, memory_clock_outputs,
    local_bus_clock_outputs, graphics_port_clock_output, strap_pin_out} == 23'h0; endproperty
  a_hiz: assert property (p_hiz)
    else $error("strap buffers enabled before latch");
  a_enable: assert property (p_enable)
    else $error("strap buffers not enabled after latch");
  a_hold: assert property (p_hold)
    else $error("latched straps lost");
  a_window: assert property (p_window)
    else $error("sampling window length wrong");
  a_mode: assert property (p_mode)
    else $error("shared pin direction mixed");
  a_proc: assert property (p_proc)
    else $error("processor halt ignored");
  a_bus: assert property (p_bus)
    else $error("bus halt ignored");
  a_gfx: assert property (p_gfx)
    else $error("graphics halt ignored");
  a_down: assert property (p_down)
    else $error("power-down ignored");
endmodule // clock_gating_props

bind clock_strap_and_output_gating clock_gating_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
  i_clock_gating_props (.clk_sys(clk_sys), .reset_n(reset_n), .power_good(power_good),
  .strap_pin_out(strap_pin_out), .strap_pin_oe_n(strap_pin_oe_n),
  .shared_memory_clock_pins_in(shared_memory_clock_pins_in),
  .shared_memory_clock_pins_oe_n(shared_memory_clock_pins_oe_n),
  .processor_clock_outputs(processor_clock_outputs),
  .memory_clock_outputs(memory_clock_outputs),
  .local_bus_clock_outputs(local_bus_clock_outputs),
  .graphics_port_clock_output(graphics_port_clock_output),
  .straps_latched(straps_latched));

/* chipset_model.sv */
`timescale 1ns/10ps
// ****************
// board straps and chipset halt drivers
// ****************
module chipset_model (
  input wire [4:0] strap_level,
  input wire [3:0] halt_level_n,
  input wire [4:0] strap_pin_out,
  input wire [4:0] strap_pin_oe_n,
  input wire [3:0] shared_pins_out,
  input wire [3:0] shared_pins_oe_n,
  output wire [4:0] strap_pin_in,
  output wire [3:0] shared_pins_in
);
  // resistor sets the level only while the device leaves the pin floating
  assign strap_pin_in = (strap_pin_oe_n & strap_level) | (~strap_pin_oe_n & strap_pin_out);
  // chipset drives halts only where the device does not drive
  assign shared_pins_in = (shared_pins_oe_n & halt_level_n) | (~shared_pins_oe_n & shared_pins_out);
endmodule // chipset_model

/* clock_strap_and_output_gating_bench.sv */
`timescale 1ns/10ps
`include "clock_strap_defines.vh"
module clock_strap_and_output_gating_bench;
  // ****************
  // stimulus and wiring
  // ****************
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg power_good = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg [4:0] strap_level = 5'h00;
  reg [3:0] halt_level_n = 4'hF;
  reg [31:0] rng = 32'h1E920A8A;
  reg [31:0] rd;
  reg [4:0] s;
  integer errors = 0;
  integer checks_done = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, gfx, straps_latched;
  wire [4:0] sp_in, sp_out, sp_oe_n, bus;
  wire [3:0] sh_in, sh_out, sh_oe_n, proc;
  wire [7:0] mem;
  wire [22:0] outs = {sp_out, bus, gfx, mem, proc};
  always #5 clk_sys = ~clk_sys;
  clock_strap_and_output_gating #(.SAMPLE_CYCLES(20)) i_clock_strap_and_output_gating (
    .clk_sys(clk_sys), .reset_n(reset_n), .power_good(power_good), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .strap_pin_in(sp_in), .strap_pin_out(sp_out), .strap_pin_oe_n(sp_oe_n),
    .shared_memory_clock_pins_in(sh_in), .shared_memory_clock_pins_out(sh_out),
    .shared_memory_clock_pins_oe_n(sh_oe_n), .processor_clock_outputs(proc),
    .memory_clock_outputs(mem), .local_bus_clock_outputs(bus),
    .graphics_port_clock_output(gfx), .straps_latched(straps_latched));
  chipset_model i_chipset_model (.strap_level(strap_level), .halt_level_n(halt_level_n),
    .strap_pin_out(sp_out), .strap_pin_oe_n(sp_oe_n), .shared_pins_out(sh_out),
    .shared_pins_oe_n(sh_oe_n), .strap_pin_in(sp_in), .shared_pins_in(sh_in));
  // ****************
  // helpers
  // ****************
  function [31:0] xorshift(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xorshift = y ^ (y << 5);
    end
  endfunction
  // outputs that a halt input must silence, order as in outs
  function [22:0] gate_mask(input integer k);
    case (k)
      0: gate_mask = 23'h001000;
      1: gate_mask = 23'h7FFFFF;
      2: gate_mask = 23'h000FFF;
      default: gate_mask = 23'h03E000;
    endcase
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // waits for ready; a stuck slave ends the run
  task wait_ready;
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n = n + 1;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
        check(32'h0, 32'h1);
        report_and_stop;
      end
    end
  endtask
  task ahb(input w, input [31:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask
  // ****************
  // scenarios
  // ****************
  task power_up(input [4:0] st);
    integer n;
    begin
      reset_n <= 1'b0;
      power_good <= 1'b0;
      strap_level <= st;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      ahb(1'b0, `REG_STATUS, 32'h0);
      check({27'h0, sp_oe_n}, 32'h1F);
      power_good <= 1'b1;
      n = 0;
      while (sp_oe_n !== 5'h00 && n < 300) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      check({27'h0, sp_oe_n}, 32'h0);
      if (sp_oe_n !== 5'h00) report_and_stop;
      ahb(1'b0, `REG_STATUS, 32'h0);
      check(rd[5:0], {1'b1, st});
      check(sh_oe_n, st[3] ? 4'h0 : 4'hF);
    end
  endtask
  // memory clock must match the rate of its selected source
  task rate_check;
    integer cp, cm, cg, e, n;
    reg [2:0] p;
    begin
      cp = 0; cm = 0; cg = 0; p = 3'h7;
      for (n = 0; n < 400; n = n + 1) begin
        @(posedge clk_sys);
        cp = cp + (proc[0] && !p[0]);
        cm = cm + (mem[0] && !p[1]);
        cg = cg + (gfx && !p[2]);
        p = {gfx, mem[0], proc[0]};
      end
      e = s[4] ? cp : cg;
      check((cm - e <= 1) && (e - cm <= 1), 1);
      $display("rate test done");
    end
  endtask
  task halt_check;
    integer k, n;
    reg [22:0] acc;
    reg [1:0] seen;
    for (k = 0; k < 4; k = k + 1) begin
      halt_level_n <= ~(4'h1 << k);
      repeat (40) @(posedge clk_sys);
      acc = 23'h0;
      seen = 2'b00;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk_sys);
        acc = acc | (outs & gate_mask(k));
        seen = seen | ((k == 0 ? sp_out[3] : sp_out[2]) ? 2'b10 : 2'b01);
      end
      check(acc, 0);
      if (k == 0 || k == 3) check(seen, 2'b11);
      halt_level_n <= 4'hF;
      repeat (30) @(posedge clk_sys);
      acc = 23'h0;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk_sys);
        acc = acc | (outs & gate_mask(k));
      end
      check(acc, gate_mask(k));
    end
    $display("halt test done");
  endtask
  task reg_check;
    reg [31:0] r;
    integer n;
    begin
      ahb(1'b1, `REG_DISABLE, 32'h0040_0000);
      ahb(1'b0, `REG_DISABLE, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, `REG_ADDRESS, 32'hD3);
      ahb(1'b1, `REG_DISABLE, 32'h0040_0000);
      ahb(1'b0, `REG_DISABLE, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, `REG_ADDRESS, {24'h0, `SLAVE_ADDRESS});
      rng = xorshift(rng);
      r = rng & 32'h07FF_FFFF;
      ahb(1'b1, `REG_DISABLE, r);
      ahb(1'b0, `REG_DISABLE, 32'h0);
      check(rd, r);
      ahb(1'b1, `REG_DISABLE, 32'h0040_0000);
      repeat (30) @(posedge clk_sys);
      r = 32'h0;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk_sys);
        r = r | gfx;
      end
      check(r, 32'h0);
      ahb(1'b1, `REG_DISABLE, 32'h0);
      ahb(1'b1, `REG_CTRL, 32'h1);
      ahb(1'b0, `REG_CTRL, 32'h0);
      check(rd, 32'h1);
      ahb(1'b1, `REG_CTRL, 32'h2C);
      ahb(1'b0, `REG_CTRL, 32'h0);
      check(rd, 32'h2C);
      ahb(1'b1, `REG_CTRL, 32'h0);
      ahb(1'b0, 32'h10, 32'h0);
      check(rd, 32'h0);
      $display("register test done");
    end
  endtask
  initial begin
    @(posedge clk_sys);
    rng = xorshift(rng);
    s = rng[4:0] & 5'h17;
    power_up(s);
    rate_check;
    reg_check;
    halt_check;
    // straps must survive strap changes and a power-good glitch
    strap_level <= ~s;
    power_good <= 1'b0;
    repeat (10) @(posedge clk_sys);
    power_good <= 1'b1;
    repeat (40) @(posedge clk_sys);
    ahb(1'b0, `REG_STATUS, 32'h0);
    check(rd[4:0], s);
    rng = xorshift(rng);
    s = {~s[4], 1'b1, rng[2:0]};
    power_up(s);
    rate_check;
    report_and_stop;
  end
endmodule // clock_strap_and_output_gating_bench
